/* src/eb_pkg.sv */
// constants, types and register map of the expansion bus port
package eb_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] REG_PORTE  = 8'h00;
  localparam logic [7:0] REG_DDRE   = 8'h01;
  localparam logic [7:0] REG_PIN_ASSIGN = 8'h02;
  localparam logic [7:0] REG_MODE       = 8'h03;
  localparam logic [7:0] REG_BUS_CTL    = 8'h04;

  // port_e_assignment_register fields
  localparam int ASG_IDLE_EN = 7;
  localparam int ASG_PIPE_EN = 5;
  localparam int ASG_E_OFF   = 4;
  localparam int ASG_BYTE_EN = 3;
  localparam int ASG_RW_EN   = 2;
  // bus-control enable bits, frozen in emulation modes
  localparam logic [7:0] ASG_CTL_MASK = 8'hBC;
  localparam logic [7:0] ASG_RST_NORM = 8'h00;
  localparam logic [7:0] ASG_RST_EMUL = 8'hAC;

  // mode register fields
  localparam int MODE_SHOW_INT = 3;
  localparam int MODE_EMUL     = 1;
  localparam int MODE_NARROW   = 0;
  // external_bus_control_register fields
  localparam int   BUS_CTL_STR  = 0;
  localparam logic RST_STRETCH  = 1'b1;
  localparam logic RST_SHOW_INT = 1'b0;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int E_HALF_NS     = 16;
  localparam int E_STRETCH_NS  = 16;
  localparam int E_HALF_CYC    = (E_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int E_STR_CYC     = (E_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CYC       = 3;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    ST_BOOT = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_ADDR = 4'b0100,
    ST_DATA = 4'b1000
  } eb_state_t;

  typedef enum logic [1:0] {
    ACC_EXT      = 2'h0,
    ACC_MAPPED   = 2'h1,
    ACC_INTERNAL = 2'h2
  } eb_kind_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        wide;
    eb_kind_t    kind;
  } eb_req_t;

  typedef struct packed {
    logic       e;
    logic [3:0] cnt;
  } eb_egen_t;

  typedef struct packed {
    eb_state_t   st;
    logic [1:0]  boot_cnt;
    logic        emul;
    logic        narrow;
    logic [7:0]  pin_asg;
    logic        stretch_en;
    logic        show_int;
    logic [7:0]  pe_data;
    logic [7:0]  pe_dir;
    eb_req_t     req;
    logic        second;
    logic        vis;
    logic [7:0]  pa;
    logic [7:0]  pa_oe;
    logic [7:0]  pb;
    logic [7:0]  pb_oe;
    logic        no_acc;
    logic        rw;
    logic        byte_strb_n;
    logic [15:0] rdata;
    logic        resp;
    logic [7:0]  reg_rd;
  } eb_core_t;

  localparam eb_core_t CORE_RST = '{
    st: ST_BOOT, boot_cnt: 2'h0, emul: 1'b0, narrow: 1'b0, pin_asg: ASG_RST_NORM,
    stretch_en: RST_STRETCH, show_int: RST_SHOW_INT, pe_data: 8'h00, pe_dir: 8'h00,
    req: '{addr: 16'h0000, wdata: 16'h0000, write: 1'b0, wide: 1'b0, kind: ACC_EXT},
    second: 1'b0, vis: 1'b0, pa: 8'h00, pa_oe: 8'h00, pb: 8'h00, pb_oe: 8'h00,
    no_acc: 1'b1, rw: 1'b1, byte_strb_n: 1'b1, rdata: 16'h0000, resp: 1'b0, reg_rd: 8'h00};

endpackage

/* src/eb_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module eb_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins and result
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* src/eb_bus_e_clock_output.sv */
// bus e clock generator, high phase optionally stretched
`timescale 1ns/1ns
module eb_bus_e_clock_output (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control and phase
  input  wire logic stretch,
  output logic      e_high,
  output logic      last
);
  eb_pkg::eb_egen_t q, d;
  logic [3:0]       len;

  always_comb begin
    len = q.e ? 4'(eb_pkg::E_HALF_CYC + (stretch ? eb_pkg::E_STR_CYC : 0)) : 4'(eb_pkg::E_HALF_CYC);
    last = (q.cnt == len - 4'h1);
    d = q;
    if (last) begin
      d.cnt = 4'h0;
      d.e   = ~q.e;
    end else begin
      d.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign e_high = q.e;
endmodule

/* src/eb_port.sv */
// expanded mode external bus port: mux bus, port e control pins
// Behaviour
// - e clock pin driven, stretched, after reset
// - disable, stretch bits shape e clock; visibility bit does not
// - narrow normal mode: free-running e clock
// - port e bit2 input with pull after reset in normal mode
// - read write enable drives rw strobe
// - wide: ports a,b carry 16-bit bus
// - emulation: port e bits 7 to 2 are bus control
// - emulation blocks writes to control enables
// - mapped internal accesses use 16-bit bus
// - narrow external word split into two bytes
// - internal ops visible only with visibility bit
// - narrow external: data on port a
// - visible/mapped: bit15 on pa7, bit0 pb0
// - narrow: ports a,b are address/data outputs
`timescale 1ns/1ns
module eb_port (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  // cpu access port
  input  wire logic            req_valid,
  input  wire eb_pkg::eb_req_t req,
  output logic                 req_ready,
  output logic                 resp_valid,
  output logic      [15:0]     resp_rdata,
  // pipe status from the core
  input  wire logic            pipe_status_high,
  input  wire logic            pipe_status_low,
  // port a and b pins
  input  wire logic [7:0]      port_a_in,
  output logic      [7:0]      port_a_out,
  output logic      [7:0]      port_a_oe,
  input  wire logic [7:0]      port_b_in,
  output logic      [7:0]      port_b_out,
  output logic      [7:0]      port_b_oe,
  // port e pins
  input  wire logic [7:0]      port_e_in,
  output logic      [7:0]      port_e_out,
  output logic      [7:0]      port_e_oe,
  output logic                 port_e_bit2_pull_en
);
  eb_pkg::eb_core_t q, d;
  logic [23:0]      pins_s;
  logic [7:0]       pa_s, pb_s, pe_s;
  logic             e_high, e_last, stretch, split;
  logic [7:0]       ctl_en, ctl_val;

  // ==========================================================================
  // pin synchroniser and e clock
  eb_sync #(.W(24)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({port_a_in, port_b_in, port_e_in}),
    .sync_out (pins_s)
  );
  assign pa_s = pins_s[23:16];
  assign pb_s = pins_s[15:8];
  assign pe_s = pins_s[7:0];

  // stretch lengthens only external data phases
  assign stretch = q.stretch_en && (q.st == eb_pkg::ST_DATA) && (q.req.kind == eb_pkg::ACC_EXT);

  eb_bus_e_clock_output u_bus_e_clock_output (
    .clk     (clk),
    .rst     (rst),
    .stretch (stretch),
    .e_high  (e_high),
    .last    (e_last)
  );

  // narrow external access: one byte lane on port a
  function automatic logic is_split(input eb_pkg::eb_core_t c);
    return c.narrow && (c.req.kind == eb_pkg::ACC_EXT);
  endfunction

  assign split     = is_split(q);
  assign req_ready = (q.st == eb_pkg::ST_IDLE) && e_high && e_last;

  // ==========================================================================
  // next state
  always_comb begin
    d        = q;
    d.resp   = 1'b0;
    d.reg_rd = 8'h00;
    // registers
    if (reg_wr && q.st != eb_pkg::ST_BOOT) begin
      unique case (reg_addr)
        eb_pkg::REG_PORTE: d.pe_data = reg_wdata;
        eb_pkg::REG_DDRE:  d.pe_dir  = reg_wdata;
        eb_pkg::REG_PIN_ASSIGN: begin
          if (q.emul) begin
            d.pin_asg = (q.pin_asg & eb_pkg::ASG_CTL_MASK) | (reg_wdata & ~eb_pkg::ASG_CTL_MASK);
          end else begin
            d.pin_asg = reg_wdata;
          end
        end
        eb_pkg::REG_MODE:    d.show_int   = reg_wdata[eb_pkg::MODE_SHOW_INT];
        eb_pkg::REG_BUS_CTL: d.stretch_en = reg_wdata[eb_pkg::BUS_CTL_STR];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        eb_pkg::REG_PORTE:  d.reg_rd = (q.pe_data & q.pe_dir) | (pe_s & ~q.pe_dir);
        eb_pkg::REG_DDRE:   d.reg_rd = q.pe_dir;
        eb_pkg::REG_PIN_ASSIGN: d.reg_rd = q.pin_asg;
        eb_pkg::REG_MODE:       d.reg_rd = {4'h0, q.show_int, 1'b0, q.emul, q.narrow};
        eb_pkg::REG_BUS_CTL:    d.reg_rd = {7'h00, q.stretch_en};
        default:            d.reg_rd = 8'h00;
      endcase
    end
    // bus sequencer
    unique case (q.st)
      eb_pkg::ST_BOOT: begin
        d.boot_cnt = q.boot_cnt + 2'h1;
        if (q.boot_cnt == 2'(eb_pkg::BOOT_CYC - 1)) begin
          d.emul   = pe_s[6];
          d.narrow = pe_s[5];
          d.pin_asg = pe_s[6] ? eb_pkg::ASG_RST_EMUL : eb_pkg::ASG_RST_NORM;
          d.pa_oe  = 8'hFF;
          d.pb_oe  = 8'hFF;
          d.st     = eb_pkg::ST_IDLE;
        end
      end
      eb_pkg::ST_IDLE: begin
        if (req_valid && req_ready) begin
          d.req     = req;
          d.second  = 1'b0;
          d.vis         = (req.kind != eb_pkg::ACC_INTERNAL) || q.show_int;
          d.no_acc      = ~d.vis;
          d.rw          = ~req.write;
          d.byte_strb_n = ~(req.wide | req.addr[0]);
          if (d.vis) begin
            d.pa = req.addr[15:8];
            d.pb = req.addr[7:0];
          end
          d.st = eb_pkg::ST_ADDR;
        end
      end
      eb_pkg::ST_ADDR: begin
        if (e_last) begin
          d.st = eb_pkg::ST_DATA;
          if (q.vis) begin
            if (split) begin
              d.pa    = (q.req.wide && !q.second) ? q.req.wdata[15:8] : q.req.wdata[7:0];
              d.pa_oe = q.req.write ? 8'hFF : 8'h00;
            end else begin
              d.pa    = q.req.wdata[15:8];
              d.pb    = q.req.wdata[7:0];
              d.pa_oe = q.req.write ? 8'hFF : 8'h00;
              d.pb_oe = q.req.write ? 8'hFF : 8'h00;
            end
          end
        end
      end
      eb_pkg::ST_DATA: begin
        if (e_last) begin
          if (split && q.req.wide && !q.second) begin
            d.rdata[15:8] = pa_s;
            d.second      = 1'b1;
            d.pa          = q.req.addr[15:8];
            d.pb          = q.req.addr[7:0] | 8'h01;
            d.pa_oe       = 8'hFF;
            d.st          = eb_pkg::ST_ADDR;
          end else begin
            if (split) begin
              d.rdata = q.req.wide ? {q.rdata[15:8], pa_s} : {8'h00, pa_s};
            end else begin
              d.rdata = {pa_s, pb_s};
            end
            d.resp    = 1'b1;
            d.no_acc      = 1'b1;
            d.rw          = 1'b1;
            d.byte_strb_n = 1'b1;
            d.pa_oe   = 8'hFF;
            d.pb_oe   = 8'hFF;
            d.st      = eb_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= eb_pkg::CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // port e pin functions
  always_comb begin
    ctl_en     = 8'h00;
    ctl_val    = 8'h00;
    ctl_en[7]  = q.pin_asg[eb_pkg::ASG_IDLE_EN];
    ctl_val[7] = q.no_acc;
    ctl_en[6]  = q.pin_asg[eb_pkg::ASG_PIPE_EN] && q.st != eb_pkg::ST_BOOT;
    ctl_val[6] = pipe_status_high;
    ctl_en[5]  = ctl_en[6];
    ctl_val[5] = pipe_status_low;
    ctl_en[4]  = ~q.pin_asg[eb_pkg::ASG_E_OFF];
    ctl_val[4] = e_high;
    ctl_en[3]  = q.pin_asg[eb_pkg::ASG_BYTE_EN];
    ctl_val[3] = q.byte_strb_n;
    ctl_en[2]  = q.pin_asg[eb_pkg::ASG_RW_EN];
    ctl_val[2] = q.rw;
  end

  for (genvar i = 0; i < 8; i++) begin : g_pe
    assign port_e_out[i] = ctl_en[i] ? ctl_val[i] : q.pe_data[i];
    assign port_e_oe[i]  = ctl_en[i] | q.pe_dir[i];
  end

  assign port_e_bit2_pull_en = ~ctl_en[2] & ~q.pe_dir[2];
  assign port_a_out = q.pa;
  assign port_a_oe  = q.pa_oe;
  assign port_b_out = q.pb;
  assign port_b_oe  = q.pb_oe;
  assign reg_rdata  = q.reg_rd;
  assign resp_valid = q.resp;
  assign resp_rdata = q.rdata;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  boot_straps_a: assert property (q.st == eb_pkg::ST_BOOT |-> port_e_oe[6:5] == 2'b00)
    else $error("mode strap pins driven during boot");
  e_pin_a: assert property (!q.pin_asg[eb_pkg::ASG_E_OFF] |-> port_e_oe[4] && port_e_out[4] == e_high)
    else $error("e clock not on its pin");
  e_run_a: assert property (q.narrow && !q.emul && !e_high && q.st == eb_pkg::ST_IDLE |-> ##[1:2] e_high)
    else $error("e clock stopped in narrow mode");
  pull_gpio_a: assert property (!q.pin_asg[eb_pkg::ASG_RW_EN] && !q.pe_dir[2] |-> port_e_bit2_pull_en)
    else $error("bit2 pull not enabled");
  rw_strobe_a: assert property (q.pin_asg[eb_pkg::ASG_RW_EN] && q.st == eb_pkg::ST_DATA |->
                                port_e_out[2] == !q.req.write)
    else $error("rw strobe wrong");
  emul_lock_a: assert property (q.emul && q.st != eb_pkg::ST_BOOT |->
                                (q.pin_asg & eb_pkg::ASG_CTL_MASK) == eb_pkg::ASG_RST_EMUL)
    else $error("emulation control enables changed");
  split_word_a: assert property (resp_valid && q.narrow && q.req.wide && q.req.kind == eb_pkg::ACC_EXT |->
                                 q.second)
    else $error("narrow word not split");
  invis_a: assert property (q.st == eb_pkg::ST_ADDR && q.req.kind == eb_pkg::ACC_INTERNAL && !q.show_int |->
                            q.no_acc)
    else $error("invisible cycle shown");
  narrow_lane_a: assert property (q.st == eb_pkg::ST_ADDR && e_last && split && q.vis && q.req.write
                                  && q.req.wide && !q.second |=> port_a_out == q.req.wdata[15:8])
    else $error("narrow high byte not on port a");
  wide_bus_a: assert property (q.st == eb_pkg::ST_ADDR && e_last && !split && q.vis && q.req.write |=>
                               port_b_out == q.req.wdata[7:0] && port_a_oe == 8'hFF)
    else $error("wide data lanes wrong");
  addr_phase_a: assert property (q.st == eb_pkg::ST_ADDR && q.vis && !q.second |->
                                 port_a_out == q.req.addr[15:8])
    else $error("address phase wrong");
  byte_strobe_a: assert property (q.pin_asg[eb_pkg::ASG_BYTE_EN] && q.st == eb_pkg::ST_DATA |->
                                  port_e_out[3] == !(q.req.wide || q.req.addr[0]))
    else $error("low byte strobe wrong");

  split_c: cover property (resp_valid && q.second);
  emul_c: cover property (reg_wr && q.emul && reg_addr == eb_pkg::REG_PIN_ASSIGN);
  rw_c: cover property (q.pin_asg[eb_pkg::ASG_RW_EN] && q.st == eb_pkg::ST_DATA && q.req.write);
endmodule

/* test/eb_mem.sv */
// external byte memory model on the multiplexed address and data bus
`timescale 1ns/1ns
module eb_mem (
  // clock and mode
  input  wire logic       clk,
  input  wire logic       narrow,
  // bus pins
  input  wire logic       e,
  input  wire logic       rw,
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  output logic      [7:0] pa_in,
  output logic      [7:0] pb_in
);
  logic [7:0]  mem [256];
  logic [15:0] a_q;
  logic [15:0] p_q;
  logic [15:0] ad;
  logic [7:0]  la_q;
  logic [7:0]  lb_q;
  logic        e_q;
  // address is what the pins held in the last low cycle of e
  assign ad = (e && !e_q) ? p_q : a_q;
  // ==========================================================================
  // read drive, released bus shows the inverse of the last value
  always_comb begin
    pa_in = ~la_q;
    pb_in = ~lb_q;
    if (e && rw && pa_oe == 8'h00) begin
      pa_in = narrow ? mem[ad[7:0]] : mem[{ad[7:1], 1'b0}];
      pb_in = mem[{ad[7:1], 1'b1}];
    end
  end
  // ==========================================================================
  // write capture during e high
  always @(posedge clk) begin
    e_q <= e;
    p_q <= {pa_out, pb_out};
    a_q <= ad;
    la_q <= pa_in;
    lb_q <= pb_in;
    if (e && !rw && pa_oe == 8'hFF) begin
      if (narrow) begin
        mem[ad[7:0]] <= pa_out;
      end else begin
        mem[{ad[7:1], 1'b0}] <= pa_out;
        mem[{ad[7:1], 1'b1}] <= pb_out;
      end
    end
  end
endmodule

/* test/eb_port_test.sv */
// self-checking bench of the expansion bus port
`timescale 1ns/1ns
module eb_port_test;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic [7:0]      reg_addr = 8'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic [7:0]      reg_rdata;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            req_valid = 1'b0;
  logic            req_ready;
  logic            resp_valid;
  eb_pkg::eb_req_t req = '0;
  logic [15:0]     resp_rdata;
  logic [15:0]     cap = 16'h0000;
  logic            ph = 1'b0;
  logic            pl = 1'b0;
  logic            lnk = 1'b0;
  logic            narrow = 1'b0;
  logic            seen = 1'b0;
  logic [7:0]      pe_in = 8'h00;
  logic [7:0]      port_a_out, port_a_oe, port_b_out, port_b_oe, port_a_in, port_b_in;
  logic [7:0]      port_e_out, port_e_oe;
  logic            port_e_bit2_pull_en;
  int              n_mismatch = 0;
  int              checks_done = 0;

  always #4 clk = ~clk;
  // slow unrelated pin activity on port e bit 0
  always #40 lnk = ~lnk;

  eb_port i_eb_port (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid,
    .req, .req_ready, .resp_valid, .resp_rdata, .pipe_status_high(ph), .pipe_status_low(pl),
    .port_a_in, .port_a_out, .port_a_oe, .port_b_in, .port_b_out, .port_b_oe,
    .port_e_in({pe_in[7:1], lnk}), .port_e_out, .port_e_oe, .port_e_bit2_pull_en);
  eb_mem i_eb_mem (.clk, .narrow, .e(port_e_out[4]), .rw(port_e_oe[2] ? port_e_out[2] : 1'b1),
    .pa_out(port_a_out), .pa_oe(port_a_oe), .pb_out(port_b_out), .pb_oe(port_b_oe),
    .pa_in(port_a_in), .pb_in(port_b_in));

  // ==========================================================================
  // bus watcher
  always @(negedge clk) begin
    if (port_e_oe[7] && port_e_out[7] === 1'b0) seen <= 1'b1;
    if (port_e_out[4] && port_e_oe[2] && port_e_out[2] === 1'b0) cap <= {port_a_out, port_b_out};
  end

  // ==========================================================================
  // tasks
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task timed_out;
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    finish_test();
  endtask

  task do_reset(input logic emul, input logic nar);
    @(posedge clk);
    rst <= 1'b1;
    pe_in <= {1'b0, emul, nar, 5'h00};
    narrow <= nar;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(16'(reg_rdata), 16'(exp));
  endtask

  task acc(input logic [15:0] a, input logic [15:0] d, input logic w, input eb_pkg::eb_kind_t k,
           output logic [15:0] q, output int n);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: a, wdata: d, write: w, wide: 1'b1, kind: k};
    for (i = 0; i < 200; i++) begin
      @(negedge clk);
      if (req_ready === 1'b1) break;
    end
    if (i == 200) timed_out();
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 1; n < 200; n++) begin
      @(negedge clk);
      if (resp_valid === 1'b1) break;
    end
    if (n == 200) timed_out();
    q = resp_rdata;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    int          k;
    int          n;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] q;
    logic        ev;
    void'($urandom(18611));
    do_reset(1'b0, 1'b1);
    check(16'(port_e_bit2_pull_en), 16'h0001);
    check(16'(port_e_oe[2]), 16'h0000);
    check(16'(port_e_oe[4]), 16'h0001);
    rchk(eb_pkg::REG_MODE, 8'h01);
    rchk(eb_pkg::REG_BUS_CTL, 8'h01);
    rchk(8'h7F, 8'h00);
    n = 0;
    ev = port_e_out[4];
    repeat (40) begin
      @(negedge clk);
      if (port_e_out[4] && !ev) n++;
      ev = port_e_out[4];
    end
    check(16'(n), 16'h000A);
    wr(eb_pkg::REG_PIN_ASSIGN, 8'h04);
    check(16'(port_e_oe[2]), 16'h0001);
    wr(eb_pkg::REG_PIN_ASSIGN, 8'h14);
    check(16'(port_e_oe[4]), 16'h0000);
    wr(eb_pkg::REG_PIN_ASSIGN, 8'h04);
    for (k = 0; k < 4; k++) begin
      a = 16'($urandom) & 16'hFFFE;
      d = 16'($urandom);
      acc(a, d, 1'b1, eb_pkg::ACC_EXT, q, n);
      check(16'(i_eb_mem.mem[a[7:0]]), 16'(d[15:8]));
      check(16'(i_eb_mem.mem[a[7:0] | 8'h01]), 16'(d[7:0]));
      acc(a, 16'h0000, 1'b0, eb_pkg::ACC_EXT, q, n);
      check(q, d);
    end
    d = 16'($urandom);
    acc(16'h0002, d, 1'b1, eb_pkg::ACC_MAPPED, q, n);
    check(cap, d);
    $display("normal narrow test done");
    do_reset(1'b1, 1'b0);
    rchk(eb_pkg::REG_PIN_ASSIGN, 8'hAC);
    check(16'(port_e_oe & 8'hBC), 16'h00BC);
    wr(eb_pkg::REG_PIN_ASSIGN, 8'h00);
    rchk(eb_pkg::REG_PIN_ASSIGN, 8'hAC);
    rchk(eb_pkg::REG_MODE, 8'h02);
    @(posedge clk);
    {ph, pl} <= 2'($urandom);
    @(negedge clk);
    check(16'(port_e_out[6:5]), 16'({ph, pl}));
    for (k = 0; k < 4; k++) begin
      a = 16'($urandom);
      d = 16'($urandom);
      acc(a, d, 1'b1, eb_pkg::ACC_EXT, q, n);
      check(16'(n), 16'h0007);
      acc(a, 16'h0000, 1'b0, eb_pkg::ACC_EXT, q, n);
      check(q, d);
    end
    wr(eb_pkg::REG_BUS_CTL, 8'h00);
    acc(16'h0010, 16'h5AA5, 1'b1, eb_pkg::ACC_EXT, q, n);
    check(16'(n), 16'h0005);
    seen = 1'b0;
    acc(16'h0020, 16'h1234, 1'b1, eb_pkg::ACC_INTERNAL, q, n);
    check(16'(seen), 16'h0000);
    wr(eb_pkg::REG_MODE, 8'h08);
    seen = 1'b0;
    acc(16'h0020, 16'h1234, 1'b1, eb_pkg::ACC_INTERNAL, q, n);
    check(16'(seen), 16'h0001);
    $display("emulation wide test done");
    finish_test();
  end
endmodule
